//--- src/gsa_fwd.v
// Forwarding sequencer toward the global register space
`timescale 1ns/1ps
module gsa_fwd (
	input wire core_clk,
	input wire rst_n,
	input wire start,
	input wire start_write,
	input wire [3:0] start_be,
	input wire [31:0] start_wdata,
	input wire [18:2] target,
	output reg g_req,
	output reg g_write,
	output reg [18:2] g_addr,
	output reg [3:0] g_be,
	output reg [31:0] g_wdata,
	input wire g_ack,
	input wire [31:0] g_rdata,
	output reg done,
	output reg [31:0] rdata
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;
	reg state;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			g_req <= 1'b0;
			g_write <= 1'b0;
			g_addr <= 17'h0_0000;
			g_be <= 4'h0;
			g_wdata <= 32'h0000_0000;
			done <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start) begin
					// R4: same byte enables
					g_be <= start_be;
					g_req <= 1'b1;
					g_write <= start_write;
					g_addr <= target;
					g_wdata <= start_wdata;
					state <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (g_ack) begin
					g_req <= 1'b0;
					// R8: completion after target answers
					rdata <= g_write ? 32'h0000_0000 : g_rdata;
					done <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // gsa_fwd

//--- src/gsa_map.vh
// Offsets, field positions and reset values of the global access window
`ifndef GSA_MAP_VH
`define GSA_MAP_VH
`define GSA_ADDR_OFFSET 12'hff8
`define GSA_DATA_OFFSET 12'hffc
`define GSA_TGT_MSB 18
`define GSA_TGT_LSB 2
`define GSA_TGT_RESET 17'h0_0000
`define GSA_ADDR_RESET 32'h0000_0000
`define GSA_DATA_RESET 32'h0000_0000
`endif

//--- src/gsa_window.v
// Per-port indirect access window into the global register space
// Functional notes
// R1: Address register holds target bits 18:2; bits 1:0 and 31:19 read zero.
// R2: Data register read returns the global register at the target address.
// R3: Data register write updates the global register at the target address.
// R4: Forwarded accesses use the byte enables of the original access.
// R5: SMBus data accesses read zero, writes ignored, nothing forwarded.
// R6: Software never targets any port's window address or data register.
// R7: Software never targets any extended config address or data register.
// R8: Data read completes only after the forwarded global read finishes.
`timescale 1ns/1ps
`include "gsa_map.vh"
module gsa_window (
	input wire core_clk,
	input wire rst_n,
	input wire cfg_req,
	input wire cfg_write,
	input wire [11:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	input wire cfg_smbus,
	output wire cfg_ready,
	output reg cfg_done,
	output reg [31:0] cfg_rdata,
	output wire g_req,
	output wire g_write,
	output wire [18:2] g_addr,
	output wire [3:0] g_be,
	output wire [31:0] g_wdata,
	input wire g_ack,
	input wire [31:0] g_rdata
);
	// Accepted-access kinds, sorted out while the window is idle
	localparam KIND_NONE = 3'b000;
	localparam KIND_ADDR_WR = 3'b001;
	localparam KIND_ADDR_RD = 3'b010;
	localparam KIND_FWD = 3'b011;
	localparam KIND_SMBUS = 3'b100;
	localparam KIND_UNMAPPED = 3'b101;
	// Window states: idle, or waiting on a forwarded access
	localparam WIN_IDLE = 1'b0;
	localparam WIN_FWD = 1'b1;
	reg [`GSA_TGT_MSB:`GSA_TGT_LSB] target_address_field;
	reg [`GSA_TGT_MSB:`GSA_TGT_LSB] next_target;
	reg win_state;
	reg next_win_state;
	reg next_cfg_done;
	reg [31:0] next_cfg_rdata;
	reg [2:0] access_kind;
	wire busy;
	wire fwd_done;
	wire [31:0] fwd_rdata;
	wire take;
	wire hit_addr;
	wire hit_data;
	wire fwd_start;
	function [7:0] be_byte;
		input be;
		begin
			be_byte = be ? 8'hff : 8'h00;
		end
	endfunction
	wire [31:0] be_mask;
	wire [31:0] addr_view;
	// Four byte enables widened to a full word mask
	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {be_byte(be[3]), be_byte(be[2]),
				be_byte(be[1]), be_byte(be[0])};
		end
	endfunction
	// Exact match of a register offset
	function reg_hit;
		input [11:0] addr;
		input [11:0] offset;
		begin
			reg_hit = addr == offset;
		end
	endfunction
	// Only enabled lanes of the field take the new value
	function [16:0] merge_field;
		input [16:0] old_value;
		input [16:0] new_value;
		input [16:0] mask;
		begin
			merge_field = (old_value & ~mask)
				| (new_value & mask);
		end
	endfunction
	assign be_mask = lane_mask(cfg_be);
	// R1: reserved bits read zero
	assign addr_view = {13'h0000, target_address_field, 2'h0};
	assign busy = win_state == WIN_FWD;
	// Stall new accesses while a forwarded one is outstanding
	assign cfg_ready = !busy;
	assign take = cfg_req && !busy;
	assign hit_addr = reg_hit(cfg_addr, `GSA_ADDR_OFFSET);
	assign hit_data = reg_hit(cfg_addr, `GSA_DATA_OFFSET);
	// R5: SMBus never forwards
	assign fwd_start = take && hit_data && !cfg_smbus;
	// R6: no self-check, a self-targeting window is undefined anyway
	// R7: extended config targets likewise left unchecked
	// The forward path wins, so of data accesses only an SMBus one completes locally
	always @* begin
		access_kind = KIND_NONE;
		if (take) begin
			if (fwd_start) begin
				access_kind = KIND_FWD;
			end else if (hit_data) begin
				access_kind = KIND_SMBUS;
			end else if (hit_addr && cfg_write) begin
				access_kind = KIND_ADDR_WR;
			end else if (hit_addr) begin
				access_kind = KIND_ADDR_RD;
			end else begin
				access_kind = KIND_UNMAPPED;
			end
		end
	end
	// Next state and completion of the accepted access
	always @* begin
		next_win_state = win_state;
		next_target = target_address_field;
		next_cfg_done = 1'b0;
		next_cfg_rdata = cfg_rdata;
		case (win_state)
		WIN_IDLE: begin
			case (access_kind)
			KIND_NONE: begin
				next_win_state = WIN_IDLE;
			end
			KIND_FWD: begin
				next_win_state = WIN_FWD;
			end
			KIND_ADDR_WR: begin
				next_cfg_done = 1'b1;
				next_cfg_rdata = 32'h0000_0000;
				// R1: writable target bits only
				next_target = merge_field(target_address_field,
					cfg_wdata[`GSA_TGT_MSB:`GSA_TGT_LSB],
					be_mask[`GSA_TGT_MSB:`GSA_TGT_LSB]);
			end
			KIND_ADDR_RD: begin
				next_cfg_done = 1'b1;
				next_cfg_rdata = addr_view;
			end
			KIND_SMBUS: begin
				// R5: read zero, write dropped
				next_cfg_done = 1'b1;
				next_cfg_rdata = 32'h0000_0000;
			end
			KIND_UNMAPPED: begin
				next_cfg_done = 1'b1;
				next_cfg_rdata = 32'h0000_0000;
			end
			default: begin
				next_win_state = WIN_IDLE;
			end
			endcase
		end
		WIN_FWD: begin
			if (fwd_done) begin
				next_win_state = WIN_IDLE;
				next_cfg_done = 1'b1;
				// R2: data read returns target value
				next_cfg_rdata = fwd_rdata;
			end
		end
		default: begin
			next_win_state = WIN_IDLE;
		end
		endcase
	end
	// Busy while a forwarded access is outstanding
	always @(posedge core_clk) begin
		if (!rst_n) begin
			win_state <= WIN_IDLE;
		end else begin
			win_state <= next_win_state;
		end
	end
	// R1: target register, reset to zero
	always @(posedge core_clk) begin
		if (!rst_n) begin
			target_address_field <= `GSA_TGT_RESET;
		end else begin
			target_address_field <= next_target;
		end
	end
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_done <= 1'b0;
		end else begin
			cfg_done <= next_cfg_done;
		end
	end
	// Read data holds until the next completion
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_rdata <= `GSA_DATA_RESET;
		end else begin
			cfg_rdata <= next_cfg_rdata;
		end
	end
	// R3: write forwarded to target
	gsa_fwd u_fwd (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(fwd_start),
		.start_write(cfg_write),
		.start_be(cfg_be),
		.start_wdata(cfg_wdata),
		.target(target_address_field),
		.g_req(g_req),
		.g_write(g_write),
		.g_addr(g_addr),
		.g_be(g_be),
		.g_wdata(g_wdata),
		.g_ack(g_ack),
		.g_rdata(g_rdata),
		.done(fwd_done),
		.rdata(fwd_rdata)
	);
endmodule // gsa_window

//--- tb/gsa_gmem.sv
// Global register space model
`timescale 1ns/1ps
module gsa_gmem(input wire core_clk,rst_n,g_req,g_write,
	input wire [18:2] g_addr,input wire [3:0] g_be,
	input wire [31:0] g_wdata,
	output reg g_ack=0,output reg [31:0] g_rdata=0);
	reg [31:0] m[16];
	reg [1:0] w=0;
	always @(posedge core_clk) begin
		g_ack<=0;
		// Idle data toggles so a stale value never matches
		g_rdata<=~g_rdata;
		if (!rst_n) begin
			for (int i=0;i<16;i++) m[i]<=0;
		end else if (g_req&&!g_ack)
			if (w) w<=w-1;
			else begin
				w<=2'($urandom);
				g_ack<=1;
				g_rdata<=m[g_addr[5:2]];
				for (int i=0;i<4;i++)
					if (g_write&&g_be[i]) m[g_addr[5:2]][i*8+:8]<=g_wdata[i*8+:8];
			end
	end
endmodule // gsa_gmem

//--- tb/gsa_window_assertions.sv
// Window port checks
`timescale 1ns/1ps
module gsa_chk(input wire core_clk,rst_n,cfg_req,cfg_smbus,cfg_ready,
	cfg_done,g_req,g_ack,input wire [11:0] cfg_addr,
	input wire [3:0] cfg_be,g_be,input wire [31:0] cfg_rdata);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire t=cfg_req&&cfg_ready;
	wire f=t&&cfg_addr==12'hffc&&!cfg_smbus;
	a_addr_zero: assert property(t&&!cfg_addr[2]|=>
		!cfg_rdata[31:19]&&!cfg_rdata[1:0]) else $error("addr");
	a_read_done: assert property(f|=>##[1:30] cfg_done) else $error("slow");
	a_fwd_req: assert property(f|=>g_req) else $error("fwd");
	a_be_same: assert property(f|=>g_be==$past(cfg_be)) else $error("be");
	a_smbus_zero: assert property(t&&cfg_smbus&&cfg_addr[2]|=>
		!cfg_rdata&&!g_req) else $error("smbus");
	a_no_early: assert property(g_req&&!g_ack|=>!cfg_done)
		else $error("soon");
	cover property(f);
	cover property(t&&cfg_smbus);
	cover property(g_ack);
endmodule // gsa_chk
bind gsa_window gsa_chk i_chk(.core_clk(core_clk),.rst_n(rst_n),
	.cfg_req(cfg_req),.cfg_smbus(cfg_smbus),.cfg_ready(cfg_ready),
	.cfg_done(cfg_done),.g_req(g_req),.g_ack(g_ack),.cfg_addr(cfg_addr),
	.cfg_be(cfg_be),.g_be(g_be),.cfg_rdata(cfg_rdata));

//--- tb/gsa_window_tb.sv
// Window bench
`timescale 1ns/1ps
module gsa_window_tb;
	reg core_clk=0,rst_n=0,cfg_req=0,cfg_write=0,cfg_smbus=0;
	reg [11:0] cfg_addr=0;
	reg [3:0] cfg_be=0,b;
	reg [31:0] cfg_wdata=0,d,q[$],sh[16];
	wire cfg_ready,cfg_done,g_req,g_write,g_ack;
	wire [31:0] cfg_rdata,g_wdata,g_rdata;
	wire [18:2] g_addr;
	wire [3:0] g_be;
	int bad_count=0,samples_checked=0,k,a;
	gsa_window i_gsa_window(.core_clk(core_clk),.rst_n(rst_n),
		.cfg_req(cfg_req),.cfg_write(cfg_write),.cfg_addr(cfg_addr),
		.cfg_be(cfg_be),.cfg_wdata(cfg_wdata),.cfg_smbus(cfg_smbus),
		.cfg_ready(cfg_ready),.cfg_done(cfg_done),.cfg_rdata(cfg_rdata),
		.g_req(g_req),.g_write(g_write),.g_addr(g_addr),.g_be(g_be),
		.g_wdata(g_wdata),.g_ack(g_ack),.g_rdata(g_rdata));
	gsa_gmem i_gsa_gmem(.core_clk(core_clk),.rst_n(rst_n),.g_req(g_req),
		.g_write(g_write),.g_addr(g_addr),.g_be(g_be),.g_wdata(g_wdata),
		.g_ack(g_ack),.g_rdata(g_rdata));
	initial forever #10 core_clk=~core_clk;
	task check(input [31:0] s,e);
		samples_checked++;
		if (s!==e) begin
			bad_count++;
			$display("unexpected %0t %h %h",$time,s,e);
		end
	endtask
	task report_and_stop;
		$display("%0d checks %0d errors",samples_checked,bad_count);
		if (!bad_count&&samples_checked) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task acc(bit w,bit [11:0] ad,bit [3:0] be,bit [31:0] dw,e,bit s);
		q.push_back(e);
		{cfg_req,cfg_write,cfg_addr,cfg_be}<={1'b1,w,ad,be};
		{cfg_wdata,cfg_smbus}<={dw,s};
		k=0;
		@(negedge core_clk);
		while (!cfg_ready&&k<50) begin
			k++;
			@(negedge core_clk);
		end
		if (k==50) begin
			bad_count++;
			report_and_stop;
		end
		@(posedge core_clk);
	endtask
	// A completion with no request noted is a mismatch as well
	always @(posedge core_clk)
		if (cfg_done===1'b1) begin
			if (q.size()==0) bad_count++;
			else check(cfg_rdata,q.pop_front());
		end
	initial begin
		a=$urandom(97386);
		for (k=0;k<16;k++) sh[k]=0;
		repeat(16) @(posedge core_clk);
		rst_n<=1;
		acc(0,12'hff8,4'hf,0,0,0);
		acc(1,12'hff8,4'hf,'1,0,0);
		acc(0,12'hff8,4'hf,0,32'h0007_fffc,0);
		acc(1,12'hff8,4'h2,0,0,0);
		acc(0,12'hff8,4'hf,0,32'h0007_00fc,0);
		repeat(12) begin
			a=$urandom%16;
			d=$urandom;
			b=$urandom;
			acc(1,12'hff8,4'hf,a*4,0,0);
			acc(1,12'hffc,b,d,0,d[9]);
			for (k=0;k<4;k++)
				if (b[k]&&!d[9]) sh[a][k*8+:8]=d[k*8+:8];
			acc(0,12'hffc,4'hf,0,sh[a],0);
			acc(0,12'hffc,b,0,0,1);
		end
		cfg_req<=0;
		repeat(8) @(posedge core_clk);
		// Every request must have produced its completion
		if (q.size()!=0) bad_count++;
		report_and_stop;
	end
endmodule // gsa_window_tb
